// File: ffop_pkg.sv
// Constants, field layouts and helper decoding for the flag offset FIFO block.
// Assumes one 125 MHz clock; all FIFO port controls come from logic on that clock.
//
// Functional notes
// - Fall-through occupancy counts the output register; half-full at 65538, full at 131073.
// - Fall-through almost-full asserts when occupancy reaches 131073 minus full offset.
// - Serial load low and shift low: one bit per edge, empty LSB first.
// - Serial set is 36 bits byte-wide on both ports, otherwise 34 bits.
// - Load low with shift enable high shifts nothing.
// - FIFO writes may interleave with serial loading; shifting resumes at next bit.
// - After serial loading starts, almost flags stay invalid until the last bit.
// - Almost flags become valid two clock edges after their offset is complete.
// - Offsets are read back only on the parallel read bus; the code also returns them on the register port.
// - Parallel load takes 4 writes with wide input, 6 with byte-wide input.
// - Load and write enable low store empty low, empty high, full low, full high.
// - Separate write and read offset pointers advance independently.
// - Master reset returns both pointers to empty low; partial reset keeps them.
// - Load high sends writes to memory; load low resumes the offset sequence.
// - Each almost flag is invalid until its own offset parts are written.
// - Load and read enable low put the next offset part on the read bus.
// - Readback takes 4 or 6 reads and wraps from full back to empty.
// - Interrupted readback resumes at the same pointer when both are low again.
// - Readback overwrites the read bus word, in standard and fall-through modes.
// - Offsets use 17 bits in wide modes, 18 byte-wide; other bits are ignored.
// - Loading method is latched only during master reset.
// - Load high at master reset selects serial; selects also load a default pair.
package ffop_pkg;
  localparam int          OFF_W           = 18;
  localparam int          DATA_W          = 18;
  localparam int          PART_W          = 9;
  localparam int          ADDR_W          = 17;
  localparam int          MEM_DEPTH       = 131072;
  localparam logic [17:0] CAP_STD         = 18'h20000;
  localparam logic [17:0] HALF_STD        = 18'h10001;
  localparam logic [5:0]  SER_BITS_WIDE   = 6'h22;
  localparam logic [5:0]  SER_BITS_NARROW = 6'h24;
  localparam logic [2:0]  PARTS_WIDE      = 3'h2;
  localparam logic [2:0]  PARTS_NARROW    = 3'h3;
  localparam logic [3:0]  SLICE_WIDE      = 4'h9;
  localparam logic [3:0]  SLICE_NARROW    = 4'h8;
  localparam logic [8:0]  SMASK_WIDE      = 9'h1ff;
  localparam logic [8:0]  SMASK_NARROW    = 9'h0ff;
  localparam logic [17:0] OFF_MASK_WIDE   = 18'h1ffff;
  localparam logic [17:0] OFF_MASK_NARROW = 18'h3ffff;
  localparam logic [1:0]  SETTLE_EDGES    = 2'h2;
  // Default offset pair, indexed by {load, select0, select1}.
  localparam logic [17:0] DEF_LLH = 18'h03fff;
  localparam logic [17:0] DEF_LHL = 18'h01fff;
  localparam logic [17:0] DEF_LHH = 18'h00fff;
  localparam logic [17:0] DEF_HLH = 18'h007ff;
  localparam logic [17:0] DEF_HLL = 18'h003ff;
  localparam logic [17:0] DEF_HHL = 18'h001ff;
  localparam logic [17:0] DEF_HHH = 18'h000ff;
  localparam logic [17:0] DEF_LLL = 18'h0007f;
  // Register map of the control bus.
  localparam int          AXI_AW        = 8;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_EMPTY_OFF = 8'h08;
  localparam logic [7:0]  REG_FULL_OFF  = 8'h0c;
  localparam logic [7:0]  REG_MODE      = 8'h10;
  localparam int          CTRL_CLR_BIT  = 0;
  localparam int          STAT_FLAG_LSB = 24;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  function automatic logic [17:0] ffop_default(input logic ld, input logic f0, input logic f1);
    case ({ld, f0, f1})
      3'h1:    ffop_default = DEF_LLH;
      3'h2:    ffop_default = DEF_LHL;
      3'h3:    ffop_default = DEF_LHH;
      3'h5:    ffop_default = DEF_HLH;
      3'h4:    ffop_default = DEF_HLL;
      3'h6:    ffop_default = DEF_HHL;
      3'h7:    ffop_default = DEF_HHH;
      default: ffop_default = DEF_LLL;
    endcase
  endfunction
endpackage

// File: ffop_off_if.sv
// Signals between the FIFO core and its offset register unit.
// Assumes both ends run on the same clock.
interface ffop_off_if;
  import ffop_pkg::*;
  logic              mclr;
  logic              ser_mode;
  logic              in_wide;
  logic              out_wide;
  logic              narrow;
  logic [OFF_W-1:0]  def_off;
  logic              shift_en;
  logic              ser_bit;
  logic              pwr_en;
  logic [PART_W-1:0] wdata;
  logic              prd_en;
  logic [OFF_W-1:0]  empty_off;
  logic [OFF_W-1:0]  full_off;
  logic              pae_ok;
  logic              paf_ok;
  logic [PART_W-1:0] rd_part;
  modport regs (input mclr, ser_mode, in_wide, out_wide, narrow, def_off, shift_en, ser_bit,
                input pwr_en, wdata, prd_en, output empty_off, full_off, pae_ok, paf_ok, rd_part);
  modport core (output mclr, ser_mode, in_wide, out_wide, narrow, def_off, shift_en, ser_bit,
                output pwr_en, wdata, prd_en, input empty_off, full_off, pae_ok, paf_ok, rd_part);
endinterface

// File: ffop_offset_regs.sv
// Almost-empty and almost-full offset registers with serial and parallel loading.
// Assumes the core qualifies the shift and write strobes with the latched mode, and every strobe with master reset.
module ffop_offset_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core side
  ffop_off_if.regs oif
);
  import ffop_pkg::*;

  logic [OFF_W-1:0] off_q [2];
  logic [5:0]       idx_q;
  logic [2:0]       wptr_q;
  logic [2:0]       rptr_q;
  logic [1:0]       ok_q;
  logic [1:0]       cnt_q [2];
  logic [1:0]       kill;
  logic [1:0]       arm;

  function automatic logic [2:0] parts(input logic wide);
    parts = wide ? PARTS_WIDE : PARTS_NARROW;
  endfunction
  function automatic logic [2:0] part_of(input logic [2:0] ptr, input logic wide);
    part_of = (ptr >= parts(wide)) ? ptr - parts(wide) : ptr;
  endfunction
  function automatic logic [4:0] lsb_of(input logic [2:0] ptr, input logic wide);
    lsb_of = 5'(part_of(ptr, wide) * (wide ? SLICE_WIDE : SLICE_NARROW));
  endfunction

  wire [5:0]  ser_total = oif.narrow ? SER_BITS_NARROW : SER_BITS_WIDE;
  wire [5:0]  ser_half  = ser_total >> 1;
  wire        ser_first = oif.shift_en && idx_q == 6'h00;
  wire        ser_last  = oif.shift_en && idx_q == ser_total - 6'h01;
  wire        pw_sel    = wptr_q >= parts(oif.in_wide);
  wire        pw_last   = part_of(wptr_q, oif.in_wide) == parts(oif.in_wide) - 3'h1;
  wire        pr_sel    = rptr_q >= parts(oif.out_wide);
  wire [8:0]  wmask     = oif.in_wide ? SMASK_WIDE : SMASK_NARROW;
  wire [8:0]  rmask     = oif.out_wide ? SMASK_WIDE : SMASK_NARROW;
  wire [4:0]  wlsb      = lsb_of(wptr_q, oif.in_wide);
  wire [4:0]  rlsb      = lsb_of(rptr_q, oif.out_wide);
  wire [23:0] wfield    = {15'h0000, wmask} << wlsb;
  wire [23:0] wvalue    = {15'h0000, oif.wdata & wmask} << wlsb;
  wire [23:0] wtarget   = {6'h00, off_q[pw_sel]};
  wire [23:0] wmerged   = (wtarget & ~wfield) | wvalue;
  wire [23:0] rshift    = {6'h00, off_q[pr_sel]} >> rlsb;

  assign oif.empty_off = off_q[0];
  assign oif.full_off  = off_q[1];
  assign oif.pae_ok    = ok_q[0];
  assign oif.paf_ok    = ok_q[1];
  assign oif.rd_part   = rshift[8:0] & rmask;

  // The serial path is one shared bit stream, so both flags die on its first bit.
  genvar g;
  for (g = 0; g < 2; g++) begin : g_valid
    assign kill[g] = ser_first || (oif.pwr_en && pw_sel == g[0]);
    assign arm[g]  = ser_last || (oif.pwr_en && pw_sel == g[0] && pw_last);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ok_q[g]  <= 1'b1;
        cnt_q[g] <= 2'h0;
      end else if (oif.mclr) begin
        ok_q[g]  <= 1'b1;
        cnt_q[g] <= 2'h0;
      end else if (arm[g]) begin
        ok_q[g]  <= 1'b0;
        cnt_q[g] <= SETTLE_EDGES;
      end else if (kill[g]) begin
        ok_q[g]  <= 1'b0;
        cnt_q[g] <= 2'h0;
      end else if (cnt_q[g] != 2'h0) begin
        cnt_q[g] <= cnt_q[g] - 2'h1;
        ok_q[g]  <= cnt_q[g] == 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      off_q[0] <= DEF_LLL;
      off_q[1] <= DEF_LLL;
      idx_q    <= 6'h00;
      wptr_q   <= 3'h0;
      rptr_q   <= 3'h0;
    end else if (oif.mclr) begin
      off_q[0] <= oif.def_off;
      off_q[1] <= oif.def_off;
      idx_q    <= 6'h00;
      wptr_q   <= 3'h0;
      rptr_q   <= 3'h0;
    end else begin
      if (oif.shift_en) begin
        if (idx_q < ser_half) begin
          off_q[0][idx_q[4:0]] <= oif.ser_bit;
        end else begin
          off_q[1][5'(idx_q - ser_half)] <= oif.ser_bit;
        end
        idx_q <= ser_last ? 6'h00 : idx_q + 6'h01;
      end
      if (oif.pwr_en) begin
        off_q[pw_sel] <= wmerged[17:0];
        wptr_q <= (wptr_q == 3'(2 * parts(oif.in_wide)) - 3'h1) ? 3'h0 : wptr_q + 3'h1;
      end
      if (oif.prd_en) begin
        rptr_q <= (rptr_q == 3'(2 * parts(oif.out_wide)) - 3'h1) ? 3'h0 : rptr_q + 3'h1;
      end
    end
  end
endmodule // ffop_offset_regs

// File: ffop_top.sv
// FIFO core with programmable almost flags, offset readback and an AXI4-Lite status port.
// Assumes the write and read port controls come from logic on clk, so none is synchronised.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
module ffop_top (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // FIFO resets from the port logic
  input  wire logic                      full_reset_input_n,
  input  wire logic                      pointer_clear_reset_n,
  // Straps sampled during master reset
  input  wire logic                      fall_through_mode,
  input  wire logic                      input_bus_width,
  input  wire logic                      output_bus_width,
  input  wire logic                      default_offset_select_0,
  input  wire logic                      default_offset_select_1,
  // Write port
  input  wire logic                      write_enable_n,
  input  wire logic [ffop_pkg::DATA_W-1:0] write_data_bus,
  // Read port
  input  wire logic                      read_enable_n,
  output logic      [ffop_pkg::DATA_W-1:0] read_data_bus,
  // Offset programming
  input  wire logic                      offset_load_select_n,
  input  wire logic                      serial_shift_enable_n,
  input  wire logic                      serial_data_in,
  // Status flags
  output logic                           input_ready_flag,
  output logic                           output_ready_flag,
  output logic                           half_full_flag_n,
  output logic                           almost_full_flag_n,
  output logic                           almost_empty_flag_n,
  // AXI4-Lite slave
  input  wire logic [ffop_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ffop_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import ffop_pkg::*;

  ffop_off_if oif ();

  ffop_offset_regs u_offsets (
    .clk   (clk),
    .rst_n (rst_n),
    .oif   (oif)
  );

  // Mode latched at master reset.
  logic              ser_mode_q;
  logic              fall_through_mode_q;
  logic              in_wide_q;
  logic              out_wide_q;
  logic [OFF_W-1:0]  def_off_q;

  // FIFO storage and pointers.
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [ADDR_W-1:0] wptr_q;
  logic [ADDR_W-1:0] rptr_q;
  logic [17:0]       mem_cnt_q;
  logic              out_valid_q;
  logic [DATA_W-1:0] rdata_q;

  // Flag registers.
  logic              in_rdy_q;
  logic              out_rdy_q;
  logic              hf_n_q;
  logic              af_n_q;
  logic              ae_n_q;

  // Bus slave state.
  logic              ctrl_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       axi_rdata_q;

  function automatic logic reg_known(input logic [AXI_AW-1:0] a);
    reg_known = a == REG_CTRL || a == REG_STATUS || a == REG_EMPTY_OFF ||
                a == REG_FULL_OFF || a == REG_MODE;
  endfunction

  // Port decoding.
  wire mclr      = ~full_reset_input_n;
  wire pclr      = ~pointer_clear_reset_n | ctrl_q;
  wire any_clr   = mclr | pclr;
  wire ld_act    = ~offset_load_select_n;
  wire we        = ~write_enable_n;
  wire re        = ~read_enable_n;
  wire narrow    = ~in_wide_q & ~out_wide_q;
  wire mem_full  = mem_cnt_q == CAP_STD;
  wire mem_any   = mem_cnt_q != 18'h00000;

  // Load high steers writes to memory; load low steers them to the offsets in parallel mode.
  wire fifo_we   = we & ~ld_act & ~mem_full & ~any_clr;
  wire off_rd    = re & ld_act & ~mclr;
  wire fifo_re   = re & ~ld_act & ~any_clr & (fall_through_mode_q ? out_valid_q : mem_any);
  // Readback owns the output register, so a fall-through preload waits a cycle.
  wire fall_through_mode_load = fall_through_mode_q & (~out_valid_q | fifo_re) & mem_any & ~off_rd & ~any_clr;
  wire mem_pop   = fall_through_mode_q ? fall_through_mode_load : fifo_re;

  assign oif.mclr     = mclr;
  assign oif.ser_mode = ser_mode_q;
  assign oif.in_wide  = in_wide_q;
  assign oif.out_wide = out_wide_q;
  assign oif.narrow   = narrow;
  assign oif.def_off  = ffop_default(offset_load_select_n, default_offset_select_0, default_offset_select_1);
  assign oif.shift_en = ser_mode_q & ld_act & ~serial_shift_enable_n & ~mclr;
  assign oif.ser_bit  = serial_data_in;
  assign oif.pwr_en   = ~ser_mode_q & ld_act & we & ~mclr;
  assign oif.wdata    = write_data_bus[PART_W-1:0];
  assign oif.prd_en   = off_rd;

  // Occupancy and thresholds; fall-through adds the output register as one more word.
  wire [17:0] occ     = mem_cnt_q + 18'(fall_through_mode_q & out_valid_q);
  wire [17:0] cap     = CAP_STD + 18'(fall_through_mode_q);
  wire [17:0] hf_lvl  = HALF_STD + 18'(fall_through_mode_q);
  wire [17:0] off_msk = narrow ? OFF_MASK_NARROW : OFF_MASK_WIDE;
  wire [17:0] n_eff   = oif.empty_off & off_msk;
  wire [17:0] m_eff   = oif.full_off & off_msk;
  wire        is_full = occ == cap;
  wire        is_empt = occ == 18'h00000;
  wire        hf_hit  = occ >= hf_lvl;
  wire        af_hit  = {1'b0, occ} + {1'b0, m_eff} >= {1'b0, cap};
  wire        ae_hit  = {1'b0, occ} <= {1'b0, n_eff} + 19'(fall_through_mode_q);

  // Straps are caught by the clock while master reset is held.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_mode_q <= 1'b0;
      fall_through_mode_q     <= 1'b0;
      in_wide_q  <= 1'b1;
      out_wide_q <= 1'b1;
    end else if (mclr) begin
      ser_mode_q <= offset_load_select_n;
      fall_through_mode_q     <= fall_through_mode;
      in_wide_q  <= input_bus_width;
      out_wide_q <= output_bus_width;
    end
  end

  always_ff @(posedge clk) begin
    if (fifo_we) begin
      mem[wptr_q] <= write_data_bus;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q    <= '0;
      rptr_q    <= '0;
      mem_cnt_q <= 18'h00000;
    end else if (any_clr) begin
      wptr_q    <= '0;
      rptr_q    <= '0;
      mem_cnt_q <= 18'h00000;
    end else begin
      wptr_q    <= wptr_q + ADDR_W'(fifo_we);
      rptr_q    <= rptr_q + ADDR_W'(mem_pop);
      mem_cnt_q <= mem_cnt_q + 18'(fifo_we) - 18'(mem_pop);
    end
  end

  // Output register: readback replaces whatever word stood on the read bus.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q     <= '0;
      out_valid_q <= 1'b0;
    end else if (any_clr) begin
      rdata_q     <= '0;
      out_valid_q <= 1'b0;
    end else begin
      if (off_rd) begin
        rdata_q <= DATA_W'(oif.rd_part);
      end else if (mem_pop) begin
        rdata_q <= mem[rptr_q];
      end
      if (fall_through_mode_q) begin
        out_valid_q <= fall_through_mode_load | (out_valid_q & ~fifo_re);
      end
    end
  end

  assign read_data_bus = rdata_q;

  // Outside resets, almost flags hold their last level while their offsets are being rewritten.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_rdy_q  <= 1'b1;
      out_rdy_q <= 1'b0;
      hf_n_q    <= 1'b1;
      af_n_q    <= 1'b1;
      ae_n_q    <= 1'b0;
    end else if (any_clr) begin
      in_rdy_q  <= ~fall_through_mode_q;
      out_rdy_q <= fall_through_mode_q;
      hf_n_q    <= 1'b1;
      af_n_q    <= 1'b1;
      ae_n_q    <= 1'b0;
    end else begin
      in_rdy_q  <= fall_through_mode_q ? is_full : ~is_full;
      out_rdy_q <= fall_through_mode_q ? is_empt : ~is_empt;
      hf_n_q    <= ~hf_hit;
      if (oif.paf_ok) begin
        af_n_q <= ~af_hit;
      end
      if (oif.pae_ok) begin
        ae_n_q <= ~ae_hit;
      end
    end
  end

  assign input_ready_flag    = in_rdy_q;
  assign output_ready_flag   = out_rdy_q;
  assign half_full_flag_n    = hf_n_q;
  assign almost_full_flag_n  = af_n_q;
  assign almost_empty_flag_n = ae_n_q;

  // Write channel: address and data are taken together, one write at a time.
  wire wr_go   = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  wire wr_ctrl = wr_go & s_axi_awaddr == REG_CTRL & s_axi_wstrb[0];

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= s_axi_wdata[CTRL_CLR_BIT];
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= reg_known(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel.
  wire        rd_go = s_axi_arvalid & ~rvalid_q;
  wire [31:0] stat_word;
  wire [31:0] mode_word;
  logic [31:0] rd_mux;

  assign stat_word = {3'h0, ae_n_q, af_n_q, hf_n_q, out_rdy_q, in_rdy_q, 6'h00, occ};
  assign mode_word = {26'h0000000, oif.paf_ok, oif.pae_ok, out_wide_q, in_wide_q, fall_through_mode_q, ser_mode_q};

  always_comb begin
    case (s_axi_araddr)
      REG_CTRL:      rd_mux = {31'h00000000, ctrl_q};
      REG_STATUS:    rd_mux = stat_word;
      REG_EMPTY_OFF: rd_mux = {14'h0000, n_eff};
      REG_FULL_OFF:  rd_mux = {14'h0000, m_eff};
      REG_MODE:      rd_mux = mode_word;
      default:       rd_mux = 32'h00000000;
    endcase
  end

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = axi_rdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q    <= 1'b0;
      rresp_q     <= RESP_OKAY;
      axi_rdata_q <= 32'h00000000;
    end else if (rd_go) begin
      rvalid_q    <= 1'b1;
      rresp_q     <= reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      axi_rdata_q <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule // ffop_top

// File: ffop_top_monitor.sv
// Assertions on the ports of the flag offset FIFO top.
// Assumes a bind to ffop_top; sees only its ports.
module ffop_top_monitor (
  // Clock and resets
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        full_reset_input_n,
  // FIFO side
  input wire logic        offset_load_select_n,
  input wire logic        read_enable_n,
  input wire logic [17:0] read_data_bus,
  input wire logic        half_full_flag_n,
  input wire logic        almost_empty_flag_n,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  import ffop_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer lost");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer lost");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_unmapped_read: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > 8'h13
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  a_mreset_flags: assert property (!full_reset_input_n |=> !almost_empty_flag_n && half_full_flag_n)
    else $error("flags wrong after master reset");
  a_offset_part: assert property (full_reset_input_n && !offset_load_select_n && !read_enable_n
    |=> read_data_bus[17:9] == 9'h0) else $error("offset part too wide");
endmodule // ffop_top_monitor

// File: ffop_host_model.sv
// Host logic that shifts a whole 34-bit serial offset set, one bit per clock.
// Assumes the bench holds the load input low while go is high.
module ffop_host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bench control
  input  wire logic        go,
  input  wire logic        hold,
  input  wire logic [33:0] bits,
  // Serial pins
  output logic             serial_shift_enable_n,
  output logic             serial_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] idx_q;
  // The data line toggles outside shifting so a stale bit is never mistaken for a valid one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q                 <= 6'h0;
      serial_shift_enable_n <= 1'b1;
      serial_data_in        <= 1'b0;
    end else if (go && !hold && idx_q < ffop_pkg::SER_BITS_WIDE) begin
      serial_shift_enable_n <= 1'b0;
      serial_data_in        <= bits[idx_q];
      idx_q                 <= idx_q + 6'h1;
    end else begin
      serial_shift_enable_n <= 1'b1;
      serial_data_in        <= ~serial_data_in;
    end
  end
endmodule // ffop_host_model

// File: testbench.sv
// Bench for the flag offset FIFO: offset loading, readback and the register bus.
// Assumes one 125 MHz clock; the host model shifts serial offsets.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ffop_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
  logic        clk, rst_n, mrs_n, prs_n, ld_n, wen_n, ren_n, go, hold, sen_n, sdi;
  logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [1:0]  sel, bresp, rresp, r;
  logic [7:0]  awa, ara;
  logic [17:0] wd, rd;
  logic [31:0] wdt, rdt, d;
  int          n_mismatch, comparisons, i;
  logic [8:0]  pw [4] = '{9'h005, 9'h000, 9'h1fe, 9'h1ff};
  logic [8:0]  rb [4] = '{9'h005, 9'h000, 9'h1fe, 9'h1ff};
  logic [33:0] sb = 34'h212345678;
  ffop_top DUT (.clk, .rst_n, .full_reset_input_n(mrs_n), .pointer_clear_reset_n(prs_n), .fall_through_mode(1'b0),
    .input_bus_width(1'b1), .output_bus_width(1'b1), .default_offset_select_0(sel[1]),
    .default_offset_select_1(sel[0]), .write_enable_n(wen_n), .write_data_bus(wd), .read_enable_n(ren_n),
    .read_data_bus(rd), .offset_load_select_n(ld_n), .serial_shift_enable_n(sen_n), .serial_data_in(sdi),
    .input_ready_flag(), .output_ready_flag(), .half_full_flag_n(), .almost_full_flag_n(),
    .almost_empty_flag_n(), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdt), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
  ffop_host_model u_host (.clk, .rst_n, .go, .hold, .bits(sb), .serial_shift_enable_n(sen_n), .serial_data_in(sdi));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic hold_until(ref logic s);
    @(negedge clk);
    for (i = 0; i < 20 && !s; i++) @(negedge clk);
    if (!s) begin
      n_mismatch++;
      close_out;
    end
  endtask
  task axrd(input logic [7:0] a);
    @(posedge clk);
    {ara, arv, rr} <= {a, 2'h3};
    hold_until(arr);
    @(posedge clk);
    arv <= 1'b0;
    hold_until(rv);
    {d, r} = {rdt, rresp};
    @(posedge clk);
    rr <= 1'b0;
  endtask
  task axwr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {awa, wdt, awv, wv, br} <= {a, v, 3'h7};
    hold_until(awr);
    @(posedge clk);
    {awv, wv} <= 2'h0;
    hold_until(bv);
    r = bresp;
    @(posedge clk);
    br <= 1'b0;
  endtask
  task strobe(input logic l, w, rn, input logic [17:0] v);
    @(posedge clk);
    {ld_n, wen_n, ren_n, wd} <= {l, w, rn, v};
    @(posedge clk);
    {ld_n, wen_n, ren_n} <= 3'h7;
    @(negedge clk);
  endtask
  task mreset(input logic l, input logic [1:0] s);
    @(posedge clk);
    {mrs_n, ld_n, sel} <= {1'b0, l, s};
    repeat (2) @(posedge clk);
    {mrs_n, ld_n} <= 2'h3;
    @(posedge clk);
  endtask
  initial begin
    {rst_n, mrs_n, prs_n, ld_n, wen_n, ren_n, go, hold} = 8'h7c;
    {sel, wd, awa, ara, wdt, awv, wv, br, arv, rr} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    mreset(1'b0, 2'h0);
    axrd(REG_EMPTY_OFF);
    `CHK(d, {14'h0, DEF_LLL})
    axrd(REG_MODE);
    `CHK(d[3:0], 4'hc)
    axrd(8'h40);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    axwr(8'h40, 32'h1);
    `CHK(r, RESP_SLVERR)
    $display("test register bus done");
    @(posedge clk);
    {ld_n, wen_n} <= 2'h0;
    for (int k = 0; k < 4; k++) begin
      if (k == 2) begin
        wen_n <= 1'b1;
        @(posedge clk);
        wen_n <= 1'b0;
      end
      wd <= {9'h0, pw[k]};
      @(posedge clk);
    end
    {ld_n, wen_n} <= 2'h3;
    axrd(REG_EMPTY_OFF);
    `CHK(d, {14'h0, {pw[1], pw[0]} & OFF_MASK_WIDE})
    axrd(REG_FULL_OFF);
    `CHK(d, {14'h0, {pw[3], pw[2]} & OFF_MASK_WIDE})
    strobe(1'b1, 1'b0, 1'b1, 18'h2a5a5);
    strobe(1'b1, 1'b1, 1'b0, 18'h0);
    `CHK(rd, 18'h2a5a5)
    strobe(1'b0, 1'b1, 1'b0, 18'h0);
    `CHK(rd, {9'h0, rb[0]})
    @(posedge clk);
    prs_n <= 1'b0;
    @(posedge clk);
    prs_n <= 1'b1;
    for (int k = 1; k < 6; k++) begin
      strobe(1'b0, 1'b1, 1'b0, 18'h0);
      `CHK(rd, {9'h0, rb[k % 4]})
    end
    $display("test parallel offsets done");
    mreset(1'b1, 2'h3);
    @(posedge clk);
    {ld_n, go} <= 2'h1;
    axrd(REG_FULL_OFF);
    `CHK(d, {14'h0, DEF_HHH})
    axrd(REG_MODE);
    `CHK(d[5:0], 6'h0d)
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    hold <= 1'b0;
    repeat (40) @(posedge clk);
    {ld_n, go} <= 2'h2;
    axrd(REG_MODE);
    `CHK(d[5:4], 2'h3)
    axrd(REG_EMPTY_OFF);
    `CHK(d, {15'h0, sb[16:0]})
    axrd(REG_FULL_OFF);
    `CHK(d, {15'h0, sb[33:17]})
    strobe(1'b0, 1'b1, 1'b0, 18'h0);
    `CHK(rd, {9'h0, sb[8:0]})
    $display("test serial offsets done");
    close_out;
  end
endmodule // testbench
bind ffop_top ffop_top_monitor u_mon (.clk, .rst_n, .full_reset_input_n, .offset_load_select_n, .read_enable_n,
  .read_data_bus, .half_full_flag_n, .almost_empty_flag_n, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);
